//--- vir_defs.svh
// Behaviour
// - Software assigns each request line to fast, vectored or plain class at run time.
// - Fast requests outrank all others and drive fast_interrupt_request.
// - Any one of several fast requests asserts the single fast output.
// - A readable status word shows which fast sources are requesting.
// - Sixteen vectored slots, any line to any slot; slot 0 highest, 15 lowest.
// - Vectored rank below fast and above plain; plain requests rank lowest.
// - Any pending vectored or plain request asserts normal_interrupt_request.
// - Vector register gives top pending slot address, else the shared default address.
// - A readable status word shows which normal-class requests are active.
`ifndef VIR_DEFS_SVH
`define VIR_DEFS_SVH
`define VIR_N_SLOT 16
`define VIR_SRC_W 5
`define VIR_OFF_RAW 12'h000
`define VIR_OFF_FSTAT 12'h004
`define VIR_OFF_NSTAT 12'h008
`define VIR_OFF_EN 12'h00C
`define VIR_OFF_SEL 12'h010
`define VIR_OFF_VADDR 12'h014
`define VIR_OFF_DEF 12'h018
`define VIR_SLOTADDR_PAGE 6'h04
`define VIR_SLOTCTL_PAGE 6'h08
`define VIR_CTL_EN_BIT 5
`define VIR_CTL_SRC_LSB 0
`define VIR_RST_WORD 32'h0000_0000
`endif

//--- vir_pkg.sv
package vir_pkg;
  typedef struct packed {
    logic en;
    logic [4:0] src;
  } vir_slot_s;
  typedef enum logic [1:0] {
    VIR_FAST = 2'b00,
    VIR_VECT = 2'b01,
    VIR_PLAIN = 2'b10,
    VIR_OFF = 2'b11
  } vir_class_e;
endpackage

//--- vir_ctrl.sv
`timescale 1ns/1ps
`include "vir_defs.svh"
`default_nettype none
module vir_ctrl #(
  parameter int N_SRC = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral request lines
  input wire logic [N_SRC-1:0] req_lines,
  // Core side
  output logic fast_interrupt_request,
  output logic normal_interrupt_request,
  output logic [31:0] vector_address
);
  localparam int NS = `VIR_N_SLOT;

  ////////////////////////////////////////////////////////////////
  // State
  logic [N_SRC-1:0] req_q, req_d;
  logic [N_SRC-1:0] en_q, en_d;
  logic [N_SRC-1:0] sel_q, sel_d;
  logic [31:0] def_q, def_d;
  logic [31:0] saddr_q [NS];
  logic [31:0] saddr_d [NS];
  vir_pkg::vir_slot_s sctl_q [NS];
  vir_pkg::vir_slot_s sctl_d [NS];
  logic fiq_q, fiq_d, irq_q, irq_d;
  logic [31:0] vaddr_q, vaddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;

  logic [N_SRC-1:0] fast_req, norm_req;
  logic [NS-1:0] slot_hit;
  vir_pkg::vir_class_e cls [N_SRC];
  logic setup, wr;
  logic slot_a_pg, slot_c_pg;
  logic [3:0] sidx;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign slot_a_pg = (paddr[11:6] == `VIR_SLOTADDR_PAGE);
  assign slot_c_pg = (paddr[11:6] == `VIR_SLOTCTL_PAGE);
  assign sidx = paddr[5:2];

  ////////////////////////////////////////////////////////////////
  // Classification
  assign fast_req = req_q & en_q & sel_q;
  assign norm_req = req_q & en_q & ~sel_q;

  genvar g;
  generate
    for (g = 0; g < NS; g++)
    begin : g_slot
      // Slot matches an enabled, normal-class source
      assign slot_hit[g] = sctl_q[g].en && (32'(sctl_q[g].src) < N_SRC)
        && norm_req[sctl_q[g].src];

      // Lowest pending slot index owns the vector
      a_slot_rank:
        assert property (@(posedge pclk) disable iff (!presetn)
          slot_hit[g] && ((slot_hit & ~({NS{1'b1}} << g)) == '0) |=> vector_address == $past(saddr_q[g]))
        else $error("higher slot did not win the vector");
      a_slot_class:
        assert property (@(posedge pclk) disable iff (!presetn)
          slot_hit[g] |-> cls[sctl_q[g].src] == vir_pkg::VIR_VECT)
        else $error("slot hit by a source outside the vectored class");
    end
    for (g = 0; g < N_SRC; g++)
    begin : g_cls
      always_comb
      begin
        logic in_slot;
        in_slot = 1'b0;
        for (int s = 0; s < NS; s++)
        begin
          if (sctl_q[s].en && 32'(sctl_q[s].src) == g)
          begin
            in_slot = 1'b1;
          end
        end
        if (!en_q[g])
        begin
          cls[g] = vir_pkg::VIR_OFF;
        end
        else if (sel_q[g])
        begin
          cls[g] = vir_pkg::VIR_FAST;
        end
        else if (in_slot)
        begin
          cls[g] = vir_pkg::VIR_VECT;
        end
        else
        begin
          cls[g] = vir_pkg::VIR_PLAIN;
        end
      end

      // Class map and request masks must agree
      a_class_rank:
        assert property (@(posedge pclk) disable iff (!presetn)
          fast_req[g] == (req_q[g] && cls[g] == vir_pkg::VIR_FAST)
          && norm_req[g] == (req_q[g] && (cls[g] == vir_pkg::VIR_VECT || cls[g] == vir_pkg::VIR_PLAIN)))
        else $error("request class disagrees with its rank");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Outputs and vector
  always_comb
  begin
    req_d = req_lines;
    fiq_d = |fast_req;
    irq_d = |norm_req;
    vaddr_d = def_q;
    for (int s = NS - 1; s >= 0; s--)
    begin
      if (slot_hit[s])
      begin
        vaddr_d = saddr_q[s];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register writes and reads
  always_comb
  begin
    en_d = en_q;
    sel_d = sel_q;
    def_d = def_q;
    saddr_d = saddr_q;
    sctl_d = sctl_q;
    if (wr)
    begin
      if (slot_a_pg)
      begin
        saddr_d[sidx] = pwdata;
      end
      else if (slot_c_pg)
      begin
        sctl_d[sidx].en = pwdata[`VIR_CTL_EN_BIT];
        sctl_d[sidx].src = pwdata[`VIR_CTL_SRC_LSB +: `VIR_SRC_W];
      end
      else
      begin
        case (paddr)
          `VIR_OFF_EN: en_d = pwdata[N_SRC-1:0];
          `VIR_OFF_SEL: sel_d = pwdata[N_SRC-1:0];
          `VIR_OFF_DEF: def_d = pwdata;
          default: ;
        endcase
      end
    end
    rdata_d = rdata_q;
    err_d = err_q;
    if (setup)
    begin
      rdata_d = `VIR_RST_WORD;
      err_d = 1'b0;
      if (slot_a_pg)
      begin
        rdata_d = saddr_q[sidx];
      end
      else if (slot_c_pg)
      begin
        rdata_d[`VIR_CTL_EN_BIT] = sctl_q[sidx].en;
        rdata_d[`VIR_CTL_SRC_LSB +: `VIR_SRC_W] = sctl_q[sidx].src;
      end
      else
      begin
        case (paddr)
          `VIR_OFF_RAW: rdata_d[N_SRC-1:0] = req_q;
          `VIR_OFF_FSTAT: rdata_d[N_SRC-1:0] = fast_req;
          `VIR_OFF_NSTAT: rdata_d[N_SRC-1:0] = norm_req;
          `VIR_OFF_EN: rdata_d[N_SRC-1:0] = en_q;
          `VIR_OFF_SEL: rdata_d[N_SRC-1:0] = sel_q;
          `VIR_OFF_VADDR: rdata_d = vaddr_q;
          `VIR_OFF_DEF: rdata_d = def_q;
          default: err_d = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q <= '0;
      en_q <= '0;
      sel_q <= '0;
      def_q <= `VIR_RST_WORD;
      for (int s = 0; s < NS; s++)
      begin
        saddr_q[s] <= `VIR_RST_WORD;
        sctl_q[s] <= '0;
      end
      fiq_q <= 1'b0;
      irq_q <= 1'b0;
      vaddr_q <= `VIR_RST_WORD;
      rdata_q <= `VIR_RST_WORD;
      err_q <= 1'b0;
    end
    else
    begin
      req_q <= req_d;
      en_q <= en_d;
      sel_q <= sel_d;
      def_q <= def_d;
      saddr_q <= saddr_d;
      sctl_q <= sctl_d;
      fiq_q <= fiq_d;
      irq_q <= irq_d;
      vaddr_q <= vaddr_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = err_q & psel & penable;
  assign fast_interrupt_request = fiq_q;
  assign normal_interrupt_request = irq_q;
  assign vector_address = vaddr_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_fast_merge:
    assert property ((|fast_req) |=> fast_interrupt_request)
    else $error("fast request did not raise fast output");
  a_fast_quiet:
    assert property (!(|fast_req) |=> !fast_interrupt_request)
    else $error("fast output high with no fast request");
  a_class_apart:
    assert property ((fast_req & norm_req) == '0)
    else $error("source counted in both classes");
  a_normal_merge:
    assert property ((|norm_req) |=> normal_interrupt_request)
    else $error("normal request did not raise normal output");
  a_level_hold:
    assert property ((|(req_lines & en_q & sel_q)) ##1 (en_q == $past(en_q) && sel_q == $past(sel_q))
      |=> fast_interrupt_request)
    else $error("held fast line did not keep fast output");
  a_level_drop:
    assert property (!(|(req_lines & en_q & sel_q)) ##1 (en_q == $past(en_q) && sel_q == $past(sel_q))
      |=> !fast_interrupt_request)
    else $error("fast output stayed after lines dropped");
  a_plain_quiet:
    assert property (!(|norm_req) |=> !normal_interrupt_request)
    else $error("normal output high with no normal request");

  // Vector selection and register writes
  a_slot_top:
    assert property (slot_hit[0] |=> vector_address == $past(saddr_q[0]))
    else $error("slot 0 not given top priority");
  a_vect_default:
    assert property (!(|slot_hit) |=> vector_address == $past(def_q))
    else $error("default address not given when no slot pending");
  a_class_write:
    assert property (wr && paddr == `VIR_OFF_SEL |=> sel_q == $past(pwdata[N_SRC-1:0]))
    else $error("class select write lost");
  a_enable_write:
    assert property (wr && paddr == `VIR_OFF_EN |=> en_q == $past(pwdata[N_SRC-1:0]))
    else $error("enable write lost");
  a_slot_write:
    assert property (wr && slot_c_pg |=> sctl_q[$past(sidx)]
      == $past({pwdata[`VIR_CTL_EN_BIT], pwdata[`VIR_CTL_SRC_LSB +: `VIR_SRC_W]}))
    else $error("slot control write lost");

  // Status and vector reads
  a_raw_read:
    assert property (setup && paddr == `VIR_OFF_RAW |=> prdata[N_SRC-1:0] == $past(req_q))
    else $error("raw request read wrong");
  a_vect_read:
    assert property (setup && paddr == `VIR_OFF_VADDR |=> prdata == $past(vaddr_q))
    else $error("vector register read wrong");
  a_fast_status:
    assert property (setup && paddr == `VIR_OFF_FSTAT |=> prdata[N_SRC-1:0] == $past(fast_req))
    else $error("fast status read wrong");
  a_norm_status:
    assert property (setup && paddr == `VIR_OFF_NSTAT |=> prdata[N_SRC-1:0] == $past(norm_req))
    else $error("normal status read wrong");

  c_fast_two: cover property ($countones(fast_req) > 1 ##1 fast_interrupt_request);
  c_vect_slot: cover property (slot_hit[3] && !slot_hit[0] ##1 vector_address == $past(saddr_q[3]));
  c_plain_only: cover property ((|norm_req) && !(|slot_hit) ##1 normal_interrupt_request);
  c_both_out: cover property (fast_interrupt_request && normal_interrupt_request);
  c_class_move: cover property (wr && paddr == `VIR_OFF_SEL && (|req_q));
endmodule
`default_nettype wire

//--- vir_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module vir_periph_model (
  // Clock
  input wire logic pclk,
  // Levels asked for by the bench
  input wire logic [31:0] want,
  // Lines to the controller
  output logic [31:0] req_lines
);
  // One merged level per peripheral, held until changed
  always_ff @(posedge pclk)
  begin
    req_lines <= want;
  end
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic fast_interrupt_request, normal_interrupt_request;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, want = 32'h0, prdata, req_lines, vector_address, rd, en, sel, def, mf, mn, ve;
  logic [31:0] sa [16];
  logic [5:0] sc [16];
  int fails = 0, checks = 0;
  vir_ctrl #(.N_SRC(32)) i_vir_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_lines(req_lines), .fast_interrupt_request(fast_interrupt_request),
    .normal_interrupt_request(normal_interrupt_request), .vector_address(vector_address));
  vir_periph_model i_vir_periph_model (.pclk(pclk), .want(want), .req_lines(req_lines));
  initial
  begin
    forever #50 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #(100 * 5000);
    fails++;
    conclude();
  end
  initial
  begin
    void'($urandom(86));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(1'b0, 12'h00C, 32'h0);
    cmp("enable reset", 32'h0, rd);
    bus(1'b0, 12'h018, 32'h0);
    cmp("default reset", 32'h0, rd);
    bus(1'b1, 12'h01C, 32'h1);
    cmp("unmapped write error", 32'h1, {31'h0, err});
    bus(1'b0, 12'h01C, 32'h0);
    cmp("unmapped read error", 32'h1, {31'h0, err});
    $display("test reset done");
    def = $urandom;
    bus(1'b1, 12'h018, def);
    for (int s = 0; s < 16; s++)
    begin
      sa[s] = $urandom;
      sc[s] = 6'($urandom);
      bus(1'b1, 12'(12'h100 + 4 * s), sa[s]);
      bus(1'b1, 12'(12'h200 + 4 * s), {26'h0, sc[s]});
      bus(1'b0, 12'(12'h100 + 4 * s), 32'h0);
      cmp("slot address", sa[s], rd);
      bus(1'b0, 12'(12'h200 + 4 * s), 32'h0);
      cmp("slot control", {26'h0, sc[s]}, rd);
    end
    for (int i = 0; i < 40; i++)
    begin
      en = $urandom | $urandom;
      sel = $urandom & $urandom & $urandom;
      bus(1'b1, 12'h00C, en);
      bus(1'b1, 12'h010, sel);
      want <= (i % 8 == 0) ? 32'h0 : $urandom & $urandom;
      repeat (4) @(posedge pclk);
      mf = want & en & sel;
      mn = want & en & ~sel;
      ve = def;
      for (int s = 15; s >= 0; s--)
        if (sc[s][5] && mn[sc[s][4:0]])
          ve = sa[s];
      cmp("fast output", {31'h0, |mf}, {31'h0, fast_interrupt_request});
      cmp("normal output", {31'h0, |mn}, {31'h0, normal_interrupt_request});
      cmp("vector output", ve, vector_address);
      bus(1'b0, 12'h000, 32'h0);
      cmp("raw requests", want, rd);
      bus(1'b0, 12'h010, 32'h0);
      cmp("class select", sel, rd);
      bus(1'b0, 12'h004, 32'h0);
      cmp("fast status", mf, rd);
      bus(1'b0, 12'h008, 32'h0);
      cmp("normal status", mn, rd);
      bus(1'b0, 12'h014, 32'h0);
      cmp("vector register", ve, rd);
      cmp("mapped read error", 32'h0, {31'h0, err});
    end
    $display("test random classes done");
    conclude();
  end
endmodule
`default_nettype wire
